/* File: src/serial_pkg.sv */
package serial_pkg;
   // frame mode from the two mode bits
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_UART8 = 2'b01,
      MODE_UART9 = 2'b10,
      MODE_UART9V = 2'b11
   } mode_t;
   // shared frame state, gray along idle-start-data-stop
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } ser_state_t;
   // serial control register layout
   typedef struct packed {
      logic frame_mode_hi;
      logic frame_mode_lo;
      logic multiproc_filter;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic transmit_done_flag;
      logic receive_done_flag;
   } serial_control_t;
endpackage

/* File: src/serial_port_baud_and_flags.sv */
`include "serial_port_defs.svh"
module serial_port_baud_and_flags
   import serial_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // special-function register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // rate source configuration
   input  wire logic [7:0] timer1_reload_high,
   input  wire logic [7:0] timer2_reload_high,
   input  wire logic [7:0] timer2_reload_low,
   input  wire logic       use_timer2,
   input  wire logic       timer2_external,
   input  wire logic       timer2_ext_clock_pin,
   // serial pins
   input  wire logic       rxd_in,
   output logic            rxd_out,
   output logic            rxd_oe_n,
   output logic            txd
);
   // elaboration check: the synchronisers below are written for two stages
   if (SYNC_STAGES != 2) begin
      $error("only two sync stages supported");
   end

   // reset release through two flops
   logic [1:0] rst_q;
   logic       rst_n;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) rst_q <= 2'b00;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // pin synchronisers; the second stage gives the level, the third marks edges
   logic rxd_m, rxd_s, rxd_p, t2p_m, t2p_s, t2p_p;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {rxd_m, rxd_s, rxd_p} <= 3'b111;
         {t2p_m, t2p_s, t2p_p} <= 3'b111;
      end else begin
         {rxd_m, rxd_s, rxd_p} <= {rxd_in, rxd_m, rxd_s};
         {t2p_m, t2p_s, t2p_p} <= {timer2_ext_clock_pin, t2p_m, t2p_s};
      end
   end

   serial_control_t      serial_control;
   logic [7:0] power_control;
   mode_t      mode;
   logic       baud_doubler_bit;
   assign mode = mode_t'({serial_control.frame_mode_hi, serial_control.frame_mode_lo});
   assign baud_doubler_bit = power_control[`POWER_CONTROL_DOUBLER_BIT];

   // baud generation state
   logic [3:0]  pre12, next_pre12;
   logic [7:0]  t1_cnt, next_t1_cnt;
   logic        t1_half, next_t1_half;
   logic [15:0] t2_cnt, next_t2_cnt;
   logic        t2_pre, next_t2_pre;
   logic [1:0]  m2_cnt, next_m2_cnt;
   logic        shift_tick, t1_ovf, t1_tick, t2_adv, t2_ovf;
   logic        var_tick, m2_tick, tick16, var_mode;

   // tick decode; the 16x tick paces modes 1 to 3
   always_comb begin
      var_mode = mode == MODE_UART8 || mode == MODE_UART9V;
      shift_tick = pre12 == 4'(`MODE0_DIV - 1);
      t1_ovf = shift_tick && t1_cnt == 8'hFF;
      t1_tick = t1_ovf && (baud_doubler_bit || t1_half);
      t2_adv = timer2_external ? (!t2p_s && t2p_p) : t2_pre;
      t2_ovf = t2_adv && t2_cnt == 16'hFFFF;
      var_tick = use_timer2 ? t2_ovf : t1_tick;
      m2_tick = baud_doubler_bit ? m2_cnt[0] : m2_cnt == 2'(`MODE2_DIV - 1);
      tick16 = mode == MODE_UART9 ? m2_tick : var_tick;
   end

   // counter next values; timer 1 ticks at osc/12, timer 2 at osc/2 or on falling edges of its external pin
   always_comb begin
      next_pre12 = shift_tick ? 4'h0 : pre12 + 4'h1;
      next_t1_cnt = t1_cnt;
      next_t1_half = t1_half;
      // a timer not pacing the port waits at its reload value, so the
      // first bit after a mode change is not stretched by a stale count
      if (!var_mode || use_timer2) begin
         next_t1_cnt = timer1_reload_high;
         next_t1_half = 1'b0;
      end else if (t1_ovf) begin
         next_t1_cnt = timer1_reload_high;
         next_t1_half = !t1_half;
      end else if (shift_tick) begin
         next_t1_cnt = t1_cnt + 8'h01;
      end
      next_t2_pre = !t2_pre;
      next_t2_cnt = t2_cnt;
      if (!var_mode || !use_timer2 || t2_ovf)
         next_t2_cnt = {timer2_reload_high, timer2_reload_low};
      else if (t2_adv) next_t2_cnt = t2_cnt + 16'h0001;
      next_m2_cnt = m2_cnt + 2'b01;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre12 <= 4'h0;
         t1_cnt <= 8'h00;
         t1_half <= 1'b0;
         t2_cnt <= 16'h0000;
         t2_pre <= 1'b0;
         m2_cnt <= 2'b00;
      end else begin
         pre12 <= next_pre12;
         t1_cnt <= next_t1_cnt;
         t1_half <= next_t1_half;
         t2_cnt <= next_t2_cnt;
         t2_pre <= next_t2_pre;
         m2_cnt <= next_m2_cnt;
      end
   end

   // transmitter state
   ser_state_t tx_state, next_tx_state;
   logic [9:0] tx_shift, next_tx_shift;
   logic [3:0] tx_bits, next_tx_bits, tx_sub, next_tx_sub;
   logic       tx_start, ti_set, tx_last;
   assign tx_start = sfr_wr && sfr_addr == `ADDR_SERIAL_DATA;
   assign tx_last = tx_bits == (mode == MODE_UART8 ? 4'd7 : 4'd8);

   // a write while busy is ignored so a frame is never torn
   always_comb begin
      next_tx_state = tx_state;
      next_tx_shift = tx_shift;
      next_tx_bits = tx_bits;
      next_tx_sub = tx_sub;
      ti_set = 1'b0;
      unique case (tx_state)
         ST_IDLE: if (tx_start) begin
            next_tx_state = ST_START;
            next_tx_sub = 4'h0;
            next_tx_bits = 4'h0;
            if (mode == MODE_UART8) next_tx_shift = {2'b11, sfr_wdata};
            else next_tx_shift = {1'b1, serial_control.tx_ninth_bit, sfr_wdata};
         end
         ST_START: if (mode == MODE_SHIFT ? shift_tick : tick16) begin
            next_tx_sub = tx_sub + 4'h1;
            if (mode == MODE_SHIFT || tx_sub == 4'hF) next_tx_state = ST_DATA;
         end
         ST_DATA: if (mode == MODE_SHIFT) begin
            if (shift_tick) begin
               next_tx_shift = {1'b1, tx_shift[9:1]};
               next_tx_bits = tx_bits + 4'h1;
               if (tx_bits == 4'd7) begin
                  next_tx_state = ST_IDLE;
                  ti_set = 1'b1;
               end
            end
         end else if (tick16) begin
            next_tx_sub = tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
               next_tx_shift = {1'b1, tx_shift[9:1]};
               next_tx_bits = tx_bits + 4'h1;
               if (tx_last) begin
                  next_tx_state = ST_STOP;
                  ti_set = 1'b1;
               end
            end
         end
         ST_STOP: if (tick16) begin
            next_tx_sub = tx_sub + 4'h1;
            if (tx_sub == 4'hF) next_tx_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= ST_IDLE;
         tx_shift <= 10'h3FF;
         tx_bits <= 4'h0;
         tx_sub <= 4'h0;
      end else begin
         tx_state <= next_tx_state;
         tx_shift <= next_tx_shift;
         tx_bits <= next_tx_bits;
         tx_sub <= next_tx_sub;
      end
   end

   // receiver state
   ser_state_t rx_state, next_rx_state;
   logic [8:0] rx_shift, next_rx_shift;
   logic [7:0] rx_buf, next_rx_buf;
   logic [3:0] rx_bits, next_rx_bits, rx_sub, next_rx_sub;
   logic       ri_set, rx9_set, rx9_val, rx_mid, rx_ninth;
   assign rx_mid = tick16 && rx_sub == 4'(`SAMPLE_POINT);
   assign rx_ninth = mode == MODE_UART8 ? rxd_s : rx_shift[8];

   always_comb begin
      next_rx_state = rx_state;
      next_rx_shift = rx_shift;
      next_rx_buf = rx_buf;
      next_rx_bits = rx_bits;
      next_rx_sub = tick16 ? rx_sub + 4'h1 : rx_sub;
      ri_set = 1'b0;
      rx9_set = 1'b0;
      rx9_val = 1'b0;
      unique case (rx_state)
         ST_IDLE: begin
            next_rx_sub = 4'h0;
            next_rx_bits = 4'h0;
            if (serial_control.rx_enable) begin
               if (mode == MODE_SHIFT) begin
                  if (!serial_control.receive_done_flag && tx_state == ST_IDLE)
                     next_rx_state = ST_DATA;
               end else if (!rxd_s && rxd_p) begin
                  next_rx_state = ST_START;
               end
            end
         end
         ST_START: if (rx_mid) begin
            next_rx_state = rxd_s ? ST_IDLE : ST_DATA; // false start
         end
         ST_DATA: if (mode == MODE_SHIFT) begin
            if (shift_tick) begin
               next_rx_shift = {rxd_s, rx_shift[8:1]};
               next_rx_bits = rx_bits + 4'h1;
               if (rx_bits == 4'd7) begin
                  next_rx_state = ST_IDLE;
                  next_rx_buf = next_rx_shift[8:1];
                  ri_set = 1'b1;
               end
            end
         end else if (rx_mid) begin
            next_rx_shift = {rxd_s, rx_shift[8:1]};
            next_rx_bits = rx_bits + 4'h1;
            if (rx_bits == (mode == MODE_UART8 ? 4'd7 : 4'd8))
               next_rx_state = ST_STOP;
         end
         ST_STOP: if (rx_mid) begin
            next_rx_state = ST_IDLE;
            // filter: ninth bit in modes 2/3, stop bit in mode 1
            if (!serial_control.receive_done_flag &&
                (!serial_control.multiproc_filter || rx_ninth)) begin
               ri_set = 1'b1;
               rx9_set = 1'b1;
               rx9_val = rx_ninth;
               next_rx_buf = mode == MODE_UART8 ? rx_shift[8:1]
                                                : rx_shift[7:0];
            end
         end
      endcase
      if (!serial_control.rx_enable) next_rx_state = ST_IDLE;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= ST_IDLE;
         rx_shift <= 9'h000;
         rx_buf <= 8'h00;
         rx_bits <= 4'h0;
         rx_sub <= 4'h0;
      end else begin
         rx_state <= next_rx_state;
         rx_shift <= next_rx_shift;
         rx_buf <= next_rx_buf;
         rx_bits <= next_rx_bits;
         rx_sub <= next_rx_sub;
      end
   end

   // registers; a hardware set beats a software clear in the same cycle
   serial_control_t      next_serial_control;
   logic [7:0] next_power_control, next_rdata;
   logic       next_txd, next_rxd_out, next_rxd_oe_n, busy0;
   always_comb begin
      next_serial_control = serial_control;
      next_power_control = power_control;
      if (sfr_wr && sfr_addr == `ADDR_SERIAL_CONTROL)
         next_serial_control = serial_control_t'(sfr_wdata);
      if (sfr_wr && sfr_addr == `ADDR_POWER_CONTROL)
         next_power_control = sfr_wdata;
      next_serial_control.transmit_done_flag = next_serial_control.transmit_done_flag | ti_set;
      next_serial_control.receive_done_flag = next_serial_control.receive_done_flag | ri_set;
      if (rx9_set) next_serial_control.rx_ninth_bit = rx9_val;
      next_rdata = sfr_rdata;
      if (sfr_rd) begin
         unique case (sfr_addr)
            `ADDR_SERIAL_CONTROL: next_rdata = serial_control;
            `ADDR_POWER_CONTROL: next_rdata = power_control;
            `ADDR_SERIAL_DATA: next_rdata = rx_buf;
            default: next_rdata = 8'h00;
         endcase
      end
      // pins: mode 0 drives transmit data on rxd and a clock on txd
      busy0 = mode == MODE_SHIFT &&
              (tx_state == ST_DATA || rx_state == ST_DATA);
      next_rxd_oe_n = !(mode == MODE_SHIFT && tx_state == ST_DATA);
      next_rxd_out = next_rxd_oe_n ? 1'b1 : tx_shift[0];
      if (busy0) next_txd = pre12 >= 4'(`MODE0_DIV / 2);
      else if (mode == MODE_SHIFT) next_txd = 1'b1;
      else if (tx_state == ST_START) next_txd = 1'b0;
      else if (tx_state == ST_DATA) next_txd = tx_shift[0];
      else next_txd = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serial_control <= serial_control_t'(`SERIAL_CONTROL_RESET);
         power_control <= `POWER_CONTROL_RESET;
         sfr_rdata <= 8'h00;
         txd <= 1'b1;
         rxd_out <= 1'b1;
         rxd_oe_n <= 1'b1;
      end else begin
         serial_control <= next_serial_control;
         power_control <= next_power_control;
         sfr_rdata <= next_rdata;
         txd <= next_txd;
         rxd_out <= next_rxd_out;
         rxd_oe_n <= next_rxd_oe_n;
      end
   end

   // gap counter for the mode 0 rate check; a long repetition would not unroll
   logic [3:0] tick_gap, next_tick_gap;
   always_comb next_tick_gap = shift_tick ? 4'h0 : tick_gap + 4'h1;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) tick_gap <= 4'h0;
      else tick_gap <= next_tick_gap;
   end

   // checks
   tx_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      ti_set |=> serial_control.transmit_done_flag)
      else $error("transmit-done not set");
   rx_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      ri_set |=> serial_control.receive_done_flag && rx_state == ST_IDLE)
      else $error("receive-done not set");
   shift_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
      shift_tick |-> tick_gap == 4'(`MODE0_DIV - 1))
      else $error("mode 0 rate not osc/12");
   mode2_slow_a: assert property (@(posedge clock) disable iff (!rst_n)
      (mode == MODE_UART9 && !baud_doubler_bit && tick16) |=>
      (!tick16 || mode != MODE_UART9) [*3] ##1
      (tick16 || mode != MODE_UART9))
      else $error("mode 2 rate not osc/64");
   t1_reload_a: assert property (@(posedge clock) disable iff (!rst_n)
      t1_ovf |=> t1_cnt == $past(timer1_reload_high))
      else $error("timer 1 did not reload");
   t1_double_a: assert property (@(posedge clock) disable iff (!rst_n)
      (t1_ovf && !use_timer2 && mode != MODE_UART9) |->
      (var_tick == (baud_doubler_bit || t1_half)))
      else $error("doubler misapplied");
   t2_reload_a: assert property (@(posedge clock) disable iff (!rst_n)
      t2_ovf |=> t2_cnt == {$past(timer2_reload_high), $past(timer2_reload_low)})
      else $error("timer 2 did not reload");
   rx_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
      !serial_control.rx_enable |=> rx_state == ST_IDLE)
      else $error("receiving while disabled");
   mp_filter_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rx_state == ST_STOP && rx_mid && mode[1] && serial_control.multiproc_filter
       && !rx_shift[8]) |-> !ri_set)
      else $error("filter passed ninth bit 0");
   tx_ninth_a: assert property (@(posedge clock) disable iff (!rst_n)
      (tx_state == ST_IDLE && tx_start && mode[1]) |=>
      tx_shift[8] == $past(serial_control.tx_ninth_bit))
      else $error("ninth bit not loaded");
endmodule

/* File: src/serial_port_defs.svh */
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// register addresses on the special-function port
`define ADDR_POWER_CONTROL  8'h87
`define ADDR_SERIAL_CONTROL 8'h98
`define ADDR_SERIAL_DATA    8'h99
// field positions
`define POWER_CONTROL_DOUBLER_BIT 7
// reset values
`define SERIAL_CONTROL_RESET 8'h00
`define POWER_CONTROL_RESET 8'h00
// timing counts; the divisors in oscillator cycles, OVERSAMPLE and SAMPLE_POINT in 16x ticks
`define MODE0_DIV     12
`define MODE2_DIV     4
`define OVERSAMPLE    16
`define SAMPLE_POINT  7
`endif

/* File: tb/remote_station.sv */
module remote_station (
   // clock and serial lines
   input  wire logic clock,
   input  wire logic txd,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle mark level, as the pull-up would leave it
   initial line = 1'b1;

   // send start, nb data bits lsb first, then the stop level
   task automatic send(input int bclk, input int nb, input logic [8:0] d,
                       input logic stop_v);
      int i;
      @(posedge clock);
      #1 line = 1'b0;
      for (i = 0; i <= nb; i++) begin
         repeat (bclk) @(posedge clock);
         #1 line = (i == nb) ? stop_v : d[i];
      end
      repeat (bclk) @(posedge clock);
      #1 line = 1'b1;
   endtask

   // sample mid-bit; a wrong rate drifts off the pattern quickly
   task automatic recv(input int bclk, input int nb, output logic [8:0] d);
      int i;
      d = 9'h000;
      @(negedge txd);
      repeat (bclk / 2) @(posedge clock);
      for (i = 0; i < nb; i++) begin
         repeat (bclk) @(posedge clock);
         d[i] = txd;
      end
   endtask
endmodule

/* File: tb/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DLY   = 1;
   localparam int LIMIT = 40000;

   logic       clock = 1'b0;
   logic       resetn = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic       sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [7:0] timer1_reload_high = 8'hFF;
   logic       use_timer2 = 1'b0;
   logic       timer2_external = 1'b0;
   logic       timer2_ext_clock_pin = 1'b1;
   logic       rxd_in;
   logic       rxd_out;
   logic       rxd_oe_n;
   logic       txd;
   logic       line;
   logic       ext_run = 1'b0;
   logic [7:0] v;
   logic [7:0] sh0 = 8'h00;
   logic       txd_q = 1'b1;
   int         err_total = 0;
   int         n_checks = 0;
   int         cycles = 0;
   int         m;

   // 25 MHz oscillator
   always #20 clock = ~clock;

   // shared data line: the device wins only while it drives in mode 0
   assign rxd_in = rxd_oe_n ? line : rxd_out;

   serial_port_baud_and_flags dut (
      .clock                (clock),
      .resetn               (resetn),
      .sfr_addr             (sfr_addr),
      .sfr_wr               (sfr_wr),
      .sfr_rd               (sfr_rd),
      .sfr_wdata            (sfr_wdata),
      .sfr_rdata            (sfr_rdata),
      .timer1_reload_high   (timer1_reload_high),
      .timer2_reload_high   (8'hFF),
      .timer2_reload_low    (8'hFF),
      .use_timer2           (use_timer2),
      .timer2_external      (timer2_external),
      .timer2_ext_clock_pin (timer2_ext_clock_pin),
      .rxd_in               (rxd_in),
      .rxd_out              (rxd_out),
      .rxd_oe_n             (rxd_oe_n),
      .txd                  (txd)
   );

   remote_station station (
      .clock (clock),
      .txd   (txd),
      .line  (line)
   );

   task automatic final_report;
      if (err_total == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // external timer clock toggles every 5 cycles; hang guard beside it
   always @(posedge clock) begin
      cycles++;
      if (ext_run && cycles % 5 == 0)
         timer2_ext_clock_pin <= #DLY ~timer2_ext_clock_pin;
      if (cycles == LIMIT) begin
         err_total++;
         final_report;
      end
   end

   // mode 0 capture: a data bit is taken once per rise of the shift clock
   always @(posedge clock) begin
      if (!rxd_oe_n && txd && !txd_q)
         sh0 <= {rxd_out, sh0[7:1]};
      txd_q <= txd;
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #DLY;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clock);
      #DLY sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge clock);
      #DLY;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clock);
      #DLY sfr_rd = 1'b0;
      r = sfr_rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
                      input logic [7:0] mask = 8'hFF);
      logic [7:0] r;
      rd(a, r);
      chk({1'b0, r & mask}, {1'b0, exp & mask});
   endtask

   // frame out: done flag clear in the last data bit, set mid stop bit
   task automatic tx(input logic [7:0] ctl, input int bclk, input int nb,
                     input logic [8:0] d);
      logic [8:0] got;
      wr(8'h98, ctl);
      fork
         station.recv(bclk, nb, got);
         wr(8'h99, d[7:0]);
      join
      chk(got, d);
      rdc(8'h98, ctl);
      repeat (bclk - 4) @(posedge clock);
      #DLY chk({8'h00, txd}, 9'h001);
      rdc(8'h98, ctl | 8'h02);
      repeat (bclk) @(posedge clock);
   endtask

   // frame in: no receive flag early in the stop bit, outcome after it
   task automatic rx(input logic [7:0] ctl, input int bclk, input int nb,
                     input logic [8:0] d, input logic stop_v,
                     input logic [7:0] exp, input logic [7:0] mask);
      wr(8'h98, ctl);
      fork
         station.send(bclk, nb, d, stop_v);
         begin
            repeat ((nb + 1) * bclk + 4) @(posedge clock);
            rdc(8'h98, ctl, 8'hFB);
         end
      join
      rdc(8'h98, exp, mask);
      if (exp[0])
         rdc(8'h99, d[7:0]);
   endtask

   initial begin
      repeat (6) @(posedge clock);
      #DLY resetn = 1'b1;
      repeat (3) @(posedge clock);
      rdc(8'h98, 8'h00);
      rdc(8'h87, 8'h00);
      rdc(8'h55, 8'h00);
      wr(8'h55, 8'hFF);
      rdc(8'h98, 8'h00);
      for (m = 0; m < 4; m++) begin
         wr(8'h98, 8'(m << 6));
         rdc(8'h98, 8'(m << 6));
      end
      // doubler set without disturbing the other bits
      rd(8'h87, v);
      wr(8'h87, v | 8'h80);
      rdc(8'h87, 8'h80);
      tx(8'h40, 192, 8, 9'h0A5);
      rx(8'h50, 192, 8, 9'h03C, 1'b1, 8'h55, 8'hFF);
      tx(8'h88, 32, 9, 9'h15A);
      wr(8'h87, 8'h00);
      tx(8'h80, 64, 9, 9'h0C3);
      tx(8'h40, 384, 8, 9'h096);
      #DLY use_timer2 = 1'b1;
      tx(8'hC8, 32, 9, 9'h1E1);
      #DLY ext_run = 1'b1;
      timer2_external = 1'b1;
      tx(8'h40, 160, 8, 9'h02D);
      #DLY timer2_external = 1'b0;
      ext_run = 1'b0;
      rx(8'h70, 32, 8, 9'h011, 1'b0, 8'h70, 8'hFB);
      rx(8'hF0, 32, 9, 9'h022, 1'b1, 8'hF0, 8'hFB);
      rx(8'hF0, 32, 9, 9'h144, 1'b1, 8'hF5, 8'hFF);
      rx(8'h40, 32, 8, 9'h081, 1'b1, 8'h40, 8'hFF);
      // shift mode: eight bits of 12 cycles each, no timer involved
      wr(8'h98, 8'h00);
      wr(8'h99, 8'h5A);
      repeat (60) @(posedge clock);
      rdc(8'h98, 8'h00);
      chk({8'h00, rxd_oe_n}, 9'h000);
      repeat (60) @(posedge clock);
      rdc(8'h98, 8'h02);
      chk({1'b0, sh0}, 9'h05A);
      chk({8'h00, rxd_oe_n}, 9'h001);
      wr(8'h98, 8'h10);
      repeat (60) @(posedge clock);
      rdc(8'h98, 8'h10);
      repeat (60) @(posedge clock);
      rdc(8'h98, 8'h11);
      rdc(8'h99, 8'hFF);
      final_report;
   end
endmodule
